// ---- rtl/oag_pkg.sv ----
// Package for the operand address generator: mode codes, prefixes, constants.
// Assumes a single core clock; used by rtl/oag_top.sv and by the testbench.
package oag_pkg;

  // ****************************************
  // Register map (AHB-Lite byte addresses)
  // ****************************************
  localparam logic [7:0] OAG_OFF_CTRL   = 8'h00;
  localparam logic [7:0] OAG_OFF_INDEX  = 8'h04;
  localparam logic [7:0] OAG_OFF_PAGES  = 8'h08;
  localparam logic [7:0] OAG_OFF_DATA   = 8'h0C;
  localparam logic [7:0] OAG_OFF_SP     = 8'h10;
  localparam logic [7:0] OAG_OFF_INSTR  = 8'h14;
  localparam logic [7:0] OAG_OFF_OPND   = 8'h18;
  localparam logic [7:0] OAG_OFF_PC     = 8'h1C;
  localparam logic [7:0] OAG_OFF_ADDR   = 8'h20;
  localparam logic [7:0] OAG_OFF_BRANCH = 8'h24;
  localparam logic [7:0] OAG_OFF_STATUS = 8'h28;
  localparam logic [7:0] OAG_OFF_VECT   = 8'h2C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OAG_CTRL_BANKED = 0;
  localparam int OAG_CTRL_GO     = 1;
  localparam int OAG_CTRL_SEL_LO = 4;
  localparam int OAG_PG_EP       = 0;
  localparam int OAG_PG_XP       = 8;
  localparam int OAG_PG_YP       = 16;
  localparam int OAG_PG_NB       = 24;

  // ****************************************
  // Opcode constants
  // ****************************************
  localparam logic [7:0] OAG_PFX_OTHER = 8'hCE;
  localparam logic [7:0] OAG_PFX_WORD  = 8'hCF;
  localparam logic [7:0] OAG_VEC_PAGE  = 8'h00;
  localparam logic [15:0] OAG_BASE_TWO = 16'h0001;
  localparam logic [15:0] OAG_BASE_THR = 16'h0002;

  // Addressing modes, software selected
  typedef enum logic [3:0] {
    OAG_M_IMM8, OAG_M_IMM16, OAG_M_REG, OAG_M_IND, OAG_M_DISP, OAG_M_IDX,
    OAG_M_ABS8, OAG_M_ABS16, OAG_M_VEC, OAG_M_CALL, OAG_M_REL8, OAG_M_REL16,
    OAG_M_IMPL, OAG_M_RSV0, OAG_M_RSV1, OAG_M_RSV2
  } oag_mode_t;

  // Base register selection
  typedef enum logic [1:0] {OAG_B_PAIR, OAG_B_FIRST, OAG_B_SECOND, OAG_B_STACK} oag_base_t;

  typedef enum logic [1:0] {OAG_S_IDLE, OAG_S_LOW, OAG_S_HIGH} oag_state_t;

endpackage

// ---- rtl/oag_top.sv ----
// Operand and branch-target address generator with AHB-Lite register port.
// Assumes one AHB-Lite master; vector/call bytes come in through the vector register.
`timescale 1ns/1ps

// Operation
// R1: Immediate operand from bytes after opcode
// R2: Register direct selects 8 or 16-bit register
// R3: Page/bank registers only in banked variant
// R4: Indirect uses pair, first, second index
// R5: Indirect page from matching page register
// R6: Displacement adds signed byte to base
// R7: Stack base takes external stack page
// R8: Index adds signed displacement_source_register
// R9: 8-bit absolute uses base_page_register high
// R10: Absolute/call data page from extended_page_general
// R11: 16-bit absolute operand is address
// R12: Vector reads low then high PC
// R13: Vector mode only for jump/trap ops
// R14: Branch bank from new_bank_register
// R15: Indirect call reads low, next high
// R16: Short relative base plus one or two
// R17: Long relative base plus two
// R18: Implied mode has no operand bytes
// R19: Mode from low three opcode bits (code takes mode from CTRL sel_q; the bits pick base/register)
// R20: CEH and CFH are extension prefixes
// R21: Two-byte operands low byte first
// R22: Offset sums wrap at 16 bits
// R23: Unbanked pages and bank held zero
module oag_top
  import oag_pkg::*;
#(
  parameter bit BANKED_DEFAULT = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [7:0]  stack_page,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [23:0]      data_addr_q,
  output logic [23:0]      branch_addr_q,
  output logic             addr_valid_q
);

  // ****************************************
  // Registers and bus capture
  // ****************************************
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic        banked_q;
  logic [3:0]  sel_q;
  logic [15:0] pair_index_register;
  logic [15:0] first_index_register;
  logic [15:0] second_index_register;
  logic [15:0] sp_q;
  logic [7:0]  extended_page_general;
  logic [7:0]  extended_page_first_index;
  logic [7:0]  extended_page_second_index;
  logic [7:0]  new_bank_register;
  logic [7:0]  base_page_register;
  logic [7:0]  condition_flags_register;
  logic [7:0]  displacement_source_register;
  logic [7:0]  acc_lo_q;
  logic [7:0]  acc_hi_q;
  logic [7:0]  op1_q;
  logic [7:0]  op2_q;
  logic [7:0]  op3_q;
  logic [7:0]  opnd_lo_q;
  logic [7:0]  opnd_hi_q;
  logic [15:0] pc_q;
  logic        three_byte_q;
  logic        vect_strobe;
  logic        go;
  logic        go_q;
  logic        bad_vec_q;
  logic [15:0] imm_q;
  logic [15:0] reg_val_q;
  oag_state_t  state_q;
  logic [15:0] fetch_addr_q;
  logic [7:0]  fetch_page_q;
  logic [7:0]  pc_lo_q;

  wire logic       bus_take = hsel & hready & htrans[1];
  wire logic [7:0] wsel     = addr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      go_q      <= 1'b0;
    end else begin
      go_q      <= go;
      wr_pend_q <= bus_take & hwrite;
      rd_pend_q <= bus_take & ~hwrite;
      if (bus_take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  assign go          = wr_pend_q && wsel == OAG_OFF_CTRL && hwdata[OAG_CTRL_GO];
  assign vect_strobe = wr_pend_q && wsel == OAG_OFF_VECT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      banked_q <= BANKED_DEFAULT;
      sel_q <= 4'h0;
      pair_index_register <= 16'h0000;
      first_index_register <= 16'h0000;
      second_index_register <= 16'h0000;
      sp_q <= 16'h0000;
      extended_page_general <= 8'h00;
      extended_page_first_index <= 8'h00;
      extended_page_second_index <= 8'h00;
      new_bank_register <= 8'h00;
      base_page_register <= 8'h00;
      condition_flags_register <= 8'h00;
      displacement_source_register <= 8'h00;
      acc_lo_q <= 8'h00;
      acc_hi_q <= 8'h00;
      op1_q <= 8'h00;
      op2_q <= 8'h00;
      op3_q <= 8'h00;
      opnd_lo_q <= 8'h00;
      opnd_hi_q <= 8'h00;
      pc_q <= 16'h0000;
      three_byte_q <= 1'b0;
    end else if (wr_pend_q) begin
      unique case (wsel)
        OAG_OFF_CTRL: begin
          banked_q <= hwdata[OAG_CTRL_BANKED];
          sel_q    <= hwdata[OAG_CTRL_SEL_LO +: 4];
        end
        OAG_OFF_INDEX: begin
          first_index_register  <= hwdata[15:0];
          second_index_register <= hwdata[31:16];
        end
        OAG_OFF_PAGES: begin
          extended_page_general      <= hwdata[OAG_PG_EP +: 8];
          extended_page_first_index  <= hwdata[OAG_PG_XP +: 8];
          extended_page_second_index <= hwdata[OAG_PG_YP +: 8];
          new_bank_register          <= hwdata[OAG_PG_NB +: 8];
        end
        OAG_OFF_DATA: begin
          acc_lo_q <= hwdata[7:0];
          acc_hi_q <= hwdata[15:8];
          displacement_source_register <= hwdata[23:16];
          base_page_register <= hwdata[31:24];
        end
        OAG_OFF_SP: begin
          sp_q <= hwdata[15:0];
          pair_index_register <= hwdata[31:16];
        end
        OAG_OFF_INSTR: begin
          op1_q <= hwdata[7:0];
          op2_q <= hwdata[15:8];
          op3_q <= hwdata[23:16];
          condition_flags_register <= hwdata[31:24];
        end
        OAG_OFF_OPND: begin
          opnd_lo_q <= hwdata[7:0];
          opnd_hi_q <= hwdata[15:8];
        end
        OAG_OFF_PC: begin
          pc_q <= hwdata[15:0];
          three_byte_q <= hwdata[16];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  // R20: prefixed opcodes use second byte
  wire logic       prefixed = (op1_q == OAG_PFX_OTHER) || (op1_q == OAG_PFX_WORD);
  wire logic [7:0] mode_op  = prefixed ? op2_q : op1_q;
  // R19: low three bits pick register, low two bits pick base register
  wire logic [2:0] mode_bits = mode_op[2:0];
  wire oag_mode_t  mode      = oag_mode_t'(sel_q);
  wire oag_base_t  base_sel  = oag_base_t'(mode_bits[1:0]);
  // R21: operand assembled low byte first
  wire logic [15:0] opnd16   = {opnd_hi_q, opnd_lo_q};
  // R13: vector only with jump/trap (bit 2 set)
  wire logic        vec_ok   = mode_bits[2];
  // R23: unbanked pages forced to zero
  wire logic [7:0]  ep = banked_q ? extended_page_general : 8'h00;
  wire logic [7:0]  xp = banked_q ? extended_page_first_index : 8'h00;
  wire logic [7:0]  yp = banked_q ? extended_page_second_index : 8'h00;
  wire logic [7:0]  nb = banked_q ? new_bank_register : 8'h00;
  wire logic [7:0]  sp_pg = banked_q ? stack_page : 8'h00;

  logic [15:0] base_val;
  logic [7:0]  base_pg;
  logic [15:0] ofs;
  logic [23:0] daddr;
  logic [15:0] rel_base;
  logic [15:0] rel_ofs;

  always_comb begin
    // R4: indirect base from index registers
    // R5: matching page register
    // R7: stack page for stack base
    unique case (base_sel)
      OAG_B_PAIR: begin
        base_val = pair_index_register;
        base_pg  = ep;
      end
      OAG_B_FIRST: begin
        base_val = first_index_register;
        base_pg  = xp;
      end
      OAG_B_SECOND: begin
        base_val = second_index_register;
        base_pg  = yp;
      end
      OAG_B_STACK: begin
        base_val = sp_q;
        base_pg  = sp_pg;
      end
    endcase
    // R6: displacement from operand byte
    // R8: displacement from source register
    ofs = (mode == OAG_M_IDX) ? {{8{displacement_source_register[7]}}, displacement_source_register}
                              : {{8{opnd_lo_q[7]}}, opnd_lo_q};
    daddr = 24'h000000;
    unique case (mode)
      // R22: 16-bit wrap, page unchanged
      OAG_M_DISP, OAG_M_IDX: daddr = {base_pg, 16'(base_val + ofs)};
      OAG_M_IND:             daddr = {base_pg, base_val};
      // R9: base_page_register high byte
      // R10: data page from general page
      OAG_M_ABS8:            daddr = {ep, base_page_register, opnd_lo_q};
      // R11: operand is the address
      OAG_M_ABS16, OAG_M_CALL: daddr = {ep, opnd16};
      default:               daddr = 24'h000000;
    endcase
    // R16: short base plus one or two
    // R17: long base plus two
    rel_base = pc_q + ((mode == OAG_M_REL8 && !three_byte_q) ? OAG_BASE_TWO : OAG_BASE_THR);
    rel_ofs  = (mode == OAG_M_REL16) ? opnd16 : {{8{opnd_lo_q[7]}}, opnd_lo_q};
  end

  // ****************************************
  // Operand values and register reads
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imm_q <= 16'h0000;
      reg_val_q <= 16'h0000;
    end else if (go_q) begin
      // R1: immediate value from operand bytes
      imm_q <= (mode == OAG_M_IMM16) ? opnd16 : {8'h00, opnd_lo_q};
      // R2: register direct selection
      // R3: banked-only registers read zero otherwise
      // R18: implied ops with low bits 0 or 4 read the accumulator pair
      unique case (mode_bits)
        3'd0: reg_val_q <= (mode == OAG_M_IMPL) ? {acc_hi_q, acc_lo_q} : {8'h00, acc_lo_q};
        3'd1: reg_val_q <= {8'h00, base_page_register};
        3'd2: reg_val_q <= {8'h00, condition_flags_register};
        3'd3: reg_val_q <= {8'h00, nb};
        3'd4: reg_val_q <= {acc_hi_q, acc_lo_q};
        3'd5: reg_val_q <= pc_q;
        3'd6: reg_val_q <= sp_q;
        3'd7: reg_val_q <= {yp, xp};
      endcase
    end
  end

  // ****************************************
  // Address generation and table fetch
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= OAG_S_IDLE;
      data_addr_q <= 24'h000000;
      branch_addr_q <= 24'h000000;
      addr_valid_q <= 1'b0;
      fetch_addr_q <= 16'h0000;
      fetch_page_q <= 8'h00;
      pc_lo_q <= 8'h00;
      bad_vec_q <= 1'b0;
    end else begin
      unique case (state_q)
        OAG_S_IDLE: begin
          if (go_q) begin
            addr_valid_q <= 1'b0;
            bad_vec_q <= 1'b0;
            if (mode == OAG_M_VEC && !vec_ok) begin
              bad_vec_q <= 1'b1;
            end else if (mode == OAG_M_VEC) begin
              // R12: vector table in lowest region
              fetch_addr_q <= {OAG_VEC_PAGE, opnd_lo_q};
              fetch_page_q <= 8'h00;
              data_addr_q  <= 24'({OAG_VEC_PAGE, opnd_lo_q});
              state_q      <= OAG_S_LOW;
            end else if (mode == OAG_M_CALL) begin
              // R15: call table from operand address
              fetch_addr_q <= opnd16;
              fetch_page_q <= ep;
              data_addr_q  <= daddr;
              state_q      <= OAG_S_LOW;
            end else if (mode == OAG_M_REL8 || mode == OAG_M_REL16) begin
              // R14: branch bank from new bank
              branch_addr_q <= {nb, 16'(rel_base + rel_ofs)};
              addr_valid_q  <= 1'b1;
            end else begin
              data_addr_q  <= daddr;
              addr_valid_q <= 1'b1;
            end
          end
        end
        OAG_S_LOW: begin
          if (vect_strobe) begin
            pc_lo_q     <= hwdata[7:0];
            data_addr_q <= {fetch_page_q, 16'(fetch_addr_q + 16'h0001)};
            state_q     <= OAG_S_HIGH;
          end
        end
        OAG_S_HIGH: begin
          if (vect_strobe) begin
            branch_addr_q <= {nb, hwdata[7:0], pc_lo_q};
            addr_valid_q  <= 1'b1;
            state_q       <= OAG_S_IDLE;
          end
        end
        default: state_q <= OAG_S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Bus read data
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_take && !hwrite) begin
      unique case (haddr[7:0])
        OAG_OFF_CTRL:   hrdata <= {24'h000000, sel_q, 2'b00, 1'b0, banked_q};
        OAG_OFF_INDEX:  hrdata <= {second_index_register, first_index_register};
        OAG_OFF_PAGES:  hrdata <= {nb, yp, xp, ep};
        OAG_OFF_ADDR:   hrdata <= {8'h00, data_addr_q};
        OAG_OFF_BRANCH: hrdata <= {8'h00, branch_addr_q};
        OAG_OFF_STATUS: hrdata <= {imm_q, 11'h000, bad_vec_q, 2'(state_q), addr_valid_q, banked_q};
        OAG_OFF_VECT:   hrdata <= {16'h0000, reg_val_q};
        default:        hrdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_rel_short: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    (state_q == OAG_S_IDLE && go_q && mode == OAG_M_REL8 && !three_byte_q)
    |=> branch_addr_q[15:0] == 16'($past(pc_q) + 16'h0001 + {{8{$past(opnd_lo_q[7])}}, $past(opnd_lo_q)}))
    else $error("short relative target wrong");
  chk_rel_long: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    (state_q == OAG_S_IDLE && go_q && mode == OAG_M_REL16)
    |=> branch_addr_q[15:0] == 16'($past(pc_q) + 16'h0002 + $past(opnd16)))
    else $error("long relative target wrong");
  chk_abs_eight: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    (state_q == OAG_S_IDLE && go_q && mode == OAG_M_ABS8)
    |=> data_addr_q[15:0] == {$past(base_page_register), $past(opnd_lo_q)} && addr_valid_q)
    else $error("absolute 8-bit address wrong");
  chk_abs_sixteen: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (state_q == OAG_S_IDLE && go_q && mode == OAG_M_ABS16) |=> data_addr_q[15:0] == $past(opnd16))
    else $error("absolute 16-bit address wrong");
  chk_unbanked_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R23
    (!banked_q && ((state_q == OAG_S_IDLE && go_q) || (state_q == OAG_S_HIGH && vect_strobe)))
    |=> (data_addr_q[23:16] == 8'h00 || $stable(data_addr_q))
        && (branch_addr_q[23:16] == 8'h00 || $stable(branch_addr_q)))
    else $error("page nonzero without banking");
  chk_vec_region: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    (state_q == OAG_S_IDLE && go_q && mode == OAG_M_VEC && vec_ok)
    |=> data_addr_q[23:8] == 16'h0000 ##0 state_q == OAG_S_LOW)
    else $error("vector fetch outside lowest region");
  chk_vec_only: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    (state_q == OAG_S_IDLE && go_q && mode == OAG_M_VEC && !vec_ok) |=> bad_vec_q && state_q == OAG_S_IDLE)
    else $error("vector mode accepted for other op");
  chk_call_order: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    (state_q == OAG_S_LOW && vect_strobe) |=> pc_lo_q == $past(hwdata[7:0]) && state_q == OAG_S_HIGH)
    else $error("call low byte not taken first");
  chk_idx_wrap: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (state_q == OAG_S_IDLE && go_q && mode == OAG_M_IDX && base_sel == OAG_B_FIRST)
    |=> data_addr_q[15:0] == 16'($past(first_index_register)
        + {{8{$past(displacement_source_register[7])}}, $past(displacement_source_register)}))
    else $error("indexed address wrong");

endmodule

// ---- dv/oag_mem_model.sv ----
// Table memory model for vector and call fetches of the address generator.
// Assumes addr is the generator's data address output, on the same clock.
`timescale 1ns/1ps
module oag_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [23:0] addr,
  input  wire logic [3:0]  wait_cycles,
  output logic      [7:0]  rd_byte,
  output logic             rd_ready
);
  logic [23:0] last_q;
  logic [3:0]  cnt_q;

  // ****************************************
  // Access latency
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_q <= 24'h000000;
      cnt_q  <= 4'h0;
    end else begin
      last_q <= addr;
      if (addr != last_q) begin
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'hF) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  assign rd_ready = (addr == last_q) && (cnt_q >= wait_cycles);

  // byte per table address
  // Inverted pattern until the byte is ready
  always_comb begin
    rd_byte = addr[7:0] ^ addr[15:8] ^ 8'hA5;
    if (!rd_ready) begin
      rd_byte = ~rd_byte;
    end
  end
endmodule

// ---- dv/oag_top_tb.sv ----
// Self-checking bench for the operand address generator.
// Assumes a zero-wait AHB-Lite slave and oag_mem_model as the table memory.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module oag_top_tb
  import oag_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  stack_page = 8'h77;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [23:0] data_addr_q;
  logic [23:0] branch_addr_q;
  logic        addr_valid_q;
  logic [3:0]  mem_wait = 4'h0;
  logic [7:0]  mem_byte;
  logic        mem_ready;
  logic [31:0] x;
  bit          banked = 1'b1;
  int          fails = 0;
  int          total_checks = 0;
  logic [23:0] ind_exp [3] = '{24'h013333, 24'h021111, 24'h032222};

  oag_top #(.BANKED_DEFAULT(1'b1)) i_oag_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .stack_page(stack_page), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .data_addr_q(data_addr_q), .branch_addr_q(branch_addr_q), .addr_valid_q(addr_valid_q));
  oag_mem_model i_oag_mem_model (.hclk(hclk), .hresetn(hresetn), .addr(data_addr_q),
    .wait_cycles(mem_wait), .rd_byte(mem_byte), .rd_ready(mem_ready));

  always #4 hclk = ~hclk;

  // ****************************************
  // Bus and operation helpers
  // ****************************************
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic go(input logic [3:0] m, input logic [7:0] o1, input logic [7:0] o2, input logic [15:0] opnd);
    bus(OAG_OFF_INSTR, 1'b1, {16'h0, o2, o1}, x);
    bus(OAG_OFF_OPND, 1'b1, {16'h0, opnd}, x);
    bus(OAG_OFF_CTRL, 1'b1, {24'h0, m, 2'b00, 1'b1, banked}, x);
    repeat (2) @(posedge hclk);
    #1;
  endtask

  function automatic logic [7:0] tbl(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  task automatic fetch(input logic [23:0] a, input logic [3:0] w);
    logic [23:0] a1;
    a1 = {a[23:16], a[15:0] + 16'h0001};
    `CHK("table_low_addr", a, data_addr_q)
    `CHK("valid_in_fetch", 1'b0, addr_valid_q)
    bus(OAG_OFF_STATUS, 1'b0, 32'h0, x);
    `CHK("state_low", 2'd1, x[3:2])
    mem_wait <= w;
    @(posedge hclk);
    for (int i = 0; i < 40 && mem_ready !== 1'b1; i++) @(posedge hclk);
    bus(OAG_OFF_VECT, 1'b1, {24'h0, mem_byte}, x);
    repeat (2) @(posedge hclk);
    #1;
    `CHK("table_high_addr", a1, data_addr_q)
    for (int i = 0; i < 40 && mem_ready !== 1'b1; i++) @(posedge hclk);
    bus(OAG_OFF_VECT, 1'b1, {24'h0, mem_byte}, x);
    repeat (2) @(posedge hclk);
    #1;
    `CHK("table_target", {8'h04, tbl(a1), tbl(a)}, branch_addr_q)
    `CHK("table_valid", 1'b1, addr_valid_q)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK("hreadyout", 1'b1, hreadyout)
    `CHK("hresp", 1'b0, hresp)
    `CHK("valid_reset", 1'b0, addr_valid_q)
    bus(OAG_OFF_STATUS, 1'b0, 32'h0, x);
    `CHK("status_reset", 32'h1, x)
    bus(8'h30, 1'b1, 32'hFFFF_FFFF, x);
    bus(8'h30, 1'b0, 32'h0, x);
    `CHK("unmapped", 32'h0, x)
    bus(OAG_OFF_INDEX, 1'b1, 32'h2222_1111, x);
    bus(OAG_OFF_PAGES, 1'b1, 32'h0403_0201, x);
    bus(OAG_OFF_DATA, 1'b1, 32'h12FE_ABCD, x);
    bus(OAG_OFF_SP, 1'b1, 32'h3333_5500, x);
    $display("test reset done");
  endtask

  task automatic t_imm();
    go(OAG_M_IMM16, 8'h01, 8'h00, 16'hBEEF);
    bus(OAG_OFF_STATUS, 1'b0, 32'h0, x);
    `CHK("imm16", 16'hBEEF, x[31:16])
    go(OAG_M_IMM8, 8'h01, 8'h00, 16'h12AB);
    bus(OAG_OFF_STATUS, 1'b0, 32'h0, x);
    `CHK("imm8", 16'h00AB, x[31:16])
    go(OAG_M_REG, 8'h01, 8'h00, 16'h0000);
    bus(OAG_OFF_VECT, 1'b0, 32'h0, x);
    `CHK("reg_base_page", 32'h0000_0012, x)
    go(OAG_M_REG, 8'h00, 8'h00, 16'h0000);
    bus(OAG_OFF_VECT, 1'b0, 32'h0, x);
    `CHK("reg_acc_low", 32'h0000_00CD, x)
    go(OAG_M_IMPL, 8'h00, 8'h00, 16'h0000);
    bus(OAG_OFF_VECT, 1'b0, 32'h0, x);
    `CHK("impl_pair", 32'h0000_ABCD, x)
    $display("test immediate done");
  endtask

  task automatic t_ind();
    for (int s = 0; s < 3; s++) begin
      go(OAG_M_IND, s[7:0], 8'h00, 16'h0000);
      `CHK("ind_addr", ind_exp[s], data_addr_q)
    end
    `CHK("ind_valid", 1'b1, addr_valid_q)
    go(OAG_M_IND, OAG_PFX_OTHER, 8'h01, 16'h0000);
    `CHK("pfx_other", 24'h021111, data_addr_q)
    go(OAG_M_IND, OAG_PFX_WORD, 8'h02, 16'h0000);
    `CHK("pfx_word", 24'h032222, data_addr_q)
    $display("test indirect done");
  endtask

  task automatic t_disp_idx();
    go(OAG_M_DISP, 8'h01, 8'h00, 16'h0080);
    `CHK("disp_neg", 24'h021091, data_addr_q)
    go(OAG_M_DISP, 8'h02, 8'h00, 16'h007F);
    `CHK("disp_pos", 24'h0322A1, data_addr_q)
    go(OAG_M_DISP, 8'h03, 8'h00, 16'h00FF);
    `CHK("disp_stack", 24'h7754FF, data_addr_q)
    go(OAG_M_IDX, 8'h02, 8'h00, 16'h0000);
    `CHK("idx_neg", 24'h032220, data_addr_q)
    bus(OAG_OFF_INDEX, 1'b1, 32'h2222_FFF0, x);
    go(OAG_M_DISP, 8'h01, 8'h00, 16'h0020);
    `CHK("disp_wrap", 24'h020010, data_addr_q)
    go(OAG_M_IDX, 8'h01, 8'h00, 16'h0000);
    `CHK("idx_first", 24'h02FFEE, data_addr_q)
    $display("test displacement done");
  endtask

  task automatic t_abs_table();
    go(OAG_M_ABS8, 8'h00, 8'h00, 16'h0034);
    `CHK("abs8", 24'h011234, data_addr_q)
    go(OAG_M_ABS16, 8'h00, 8'h00, 16'hBEEF);
    `CHK("abs16", 24'h01BEEF, data_addr_q)
    go(OAG_M_VEC, 8'h04, 8'h00, 16'h0040);
    fetch({OAG_VEC_PAGE, 16'h0040}, 4'h0);
    go(OAG_M_CALL, 8'h00, 8'h00, 16'h12FF);
    fetch(24'h0112FF, 4'h6);
    $display("test absolute and table done");
  endtask

  task automatic t_rel();
    bus(OAG_OFF_PC, 1'b1, 32'h0000_1000, x);
    go(OAG_M_REL8, 8'h00, 8'h00, 16'h0080);
    `CHK("rel8_two", 24'h040F81, branch_addr_q)
    bus(OAG_OFF_PC, 1'b1, 32'h0001_1000, x);
    go(OAG_M_REL8, 8'h00, 8'h00, 16'h007F);
    `CHK("rel8_three", 24'h041081, branch_addr_q)
    go(OAG_M_REL16, 8'h00, 8'h00, 16'h8000);
    `CHK("rel16", 24'h049002, branch_addr_q)
    $display("test relative done");
  endtask

  task automatic t_unbanked();
    banked = 1'b0;
    go(OAG_M_ABS16, 8'h00, 8'h00, 16'hBEEF);
    `CHK("nb_abs16", 24'h00BEEF, data_addr_q)
    go(OAG_M_DISP, 8'h03, 8'h00, 16'h0001);
    `CHK("nb_stack", 24'h005501, data_addr_q)
    go(OAG_M_REL8, 8'h00, 8'h00, 16'h0080);
    `CHK("nb_rel8", 24'h000F82, branch_addr_q)
    bus(OAG_OFF_PAGES, 1'b0, 32'h0, x);
    `CHK("nb_pages", 32'h0, x)
    go(OAG_M_REG, 8'h03, 8'h00, 16'h0000);
    bus(OAG_OFF_VECT, 1'b0, 32'h0, x);
    `CHK("nb_reg_bank", 32'h0, x)
    banked = 1'b1;
    go(OAG_M_IND, 8'h00, 8'h00, 16'h0000);
    bus(OAG_OFF_PAGES, 1'b0, 32'h0, x);
    `CHK("bk_pages", 32'h0403_0201, x)
    go(OAG_M_REG, 8'h07, 8'h00, 16'h0000);
    bus(OAG_OFF_VECT, 1'b0, 32'h0, x);
    `CHK("bk_reg_pages", 32'h0000_0302, x)
    $display("test unbanked done");
  endtask

  task automatic t_badvec_reset();
    go(OAG_M_VEC, 8'h00, 8'h00, 16'h0040);
    bus(OAG_OFF_STATUS, 1'b0, 32'h0, x);
    `CHK("bad_vector", 1'b1, x[4])
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK("rst_data", 24'h0, data_addr_q)
    `CHK("rst_branch", 24'h0, branch_addr_q)
    bus(OAG_OFF_STATUS, 1'b0, 32'h0, x);
    `CHK("rst_status", 32'h1, x)
    $display("test bad vector and reset done");
  endtask

  // ****************************************
  // Verdict, watchdog, main sequence
  // ****************************************
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Roughly 60 operations of 3 to 11 cycles each; ample margin
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_imm();
    t_ind();
    t_disp_idx();
    t_abs_table();
    t_rel();
    t_unbanked();
    t_badvec_reset();
    report_and_stop();
  end
endmodule
